// >>> pkg/ssf_pkg.sv
// Package for the serial status flag block: register map, field layout,
// reset values and the carriers that join it to the shift logic.
// Assumes a single 200 MHz clock shared with the shift and bus logic.
package ssf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] SSF_OFS_STATUS = 4'h0;
  localparam logic [3:0] SSF_OFS_CTRL = 4'h4;
  localparam logic [3:0] SSF_OFS_TXHOLD = 4'h8;
  localparam logic [3:0] SSF_OFS_RXHOLD = 4'hC;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int SSF_B_TDE = 7;
  localparam int SSF_B_RDF = 6;
  localparam int SSF_B_OVR = 5;
  localparam int SSF_B_FRM = 4;
  localparam int SSF_B_PAR = 3;
  localparam int SSF_B_TFN = 2;
  localparam int SSF_B_MPI = 1;
  localparam int SSF_B_MPO = 0;
  localparam logic [7:0] SSF_STATUS_RST = 8'h84;
  // Flags cleared by read-one then write-zero
  localparam logic [7:0] SSF_CLR_MASK = 8'hF8;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int SSF_C_TE = 0;
  localparam int SSF_C_RE = 1;
  localparam int SSF_C_SYNC = 2;
  localparam int SSF_C_PEN = 3;
  localparam int SSF_C_PODD = 4;
  localparam int SSF_C_STOP2 = 5;
  localparam int SSF_C_MP = 6;
  localparam logic [6:0] SSF_CTRL_RST = 7'h00;

  localparam logic [7:0] SSF_BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic done;
    logic [7:0] data;
    logic stop;
    logic parity;
    logic mp;
  } ssf_rx_evt_s;

  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic sync_mode;
    logic parity_en;
    logic parity_odd;
    logic two_stop;
    logic mp_format;
  } ssf_cfg_s;

endpackage

// >>> hdl/ssf_status.sv
// Status flag logic of the serial unit with its Avalon-MM register slave.
// Assumes the shift logic runs on the same clock and pulses its events.
//
// How it works
// - Status loads 0x84 on reset and low power
// - Flags clear by read-one, write-zero
// - Finished flag and mp input bit read-only
// - Holding empty set on shifter load
// - Holding empty set when transmit disabled
// - Holding empty cleared by holding write
// - Receive full set on clean reception
// - Receive full cleared by holding read
// - Errors or receive off leave receive full alone
// - Reception while full sets overrun, drops byte
// - Overrun halts reception; sync halts transmit
// - Receive disable keeps error flags
// - Async zero stop bit sets framing flag
// - Only first stop bit is checked
// - Framing error stores byte, halts reception
// - Async parity mismatch sets parity flag
// - Parity error stores byte, halts reception
// - Finished flag set at last bit if empty
// - Mp bit captured; bit 0 drives mp out
`timescale 1ns/10ps

module ssf_status
  import ssf_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Low-power entry (standby, watch, subactive, subsleep)
  input wire logic low_power,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Shift logic events
  input wire logic tx_load,
  input wire logic tx_last_bit,
  input wire ssf_pkg::ssf_rx_evt_s rx_evt,
  // Shift logic controls
  output logic [7:0] tx_holding,
  output logic tx_holding_empty,
  output logic mp_bit_out,
  output ssf_pkg::ssf_cfg_s cfg,
  output logic rx_halt,
  output logic tx_halt
);

  import ssf_pkg::*;

  // Four address bits are decoded, so a narrower bus cannot reach all offsets
  if (ADDR_W < 4) begin : g_addr_chk
    $error("ssf_status: ADDR_W must be at least 4");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic [7:0] status_q;
  logic [7:0] seen_q;
  logic [6:0] ctrl_q;
  logic [7:0] tx_hold_q;
  logic [7:0] rx_hold_q;
  logic rx_halt_q;
  logic tx_halt_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req;
  logic accept;
  logic wr_acc;
  logic rd_acc;
  logic [3:0] ofs;

  assign req = read | write;
  // Access takes effect only at the edge where waitrequest is low
  assign accept = req & ~waitreq_q;
  assign wr_acc = accept & write & byteenable[0];
  assign rd_acc = accept & read;
  assign ofs = address[3:0];

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction

  // ----------------------------------------------------------------
  // Fault summary
  // ----------------------------------------------------------------
  // Any of the three error flags stops reception, and transmit too in sync mode
  function automatic logic any_fault(input logic [7:0] s);
    return s[SSF_B_OVR] | s[SSF_B_FRM] | s[SSF_B_PAR];
  endfunction

  logic fault_now;
  // Read live so an event one cycle after an error is already refused
  assign fault_now = any_fault(status_q);

  logic wr_status;
  logic wr_ctrl;
  logic wr_tx;
  logic rd_status;
  logic rd_rx;

  assign wr_status = wr_acc & hit(ofs, SSF_OFS_STATUS);
  assign wr_ctrl = wr_acc & hit(ofs, SSF_OFS_CTRL);
  assign wr_tx = wr_acc & hit(ofs, SSF_OFS_TXHOLD);
  assign rd_status = rd_acc & hit(ofs, SSF_OFS_STATUS);
  assign rd_rx = rd_acc & hit(ofs, SSF_OFS_RXHOLD);

  // Zero write with a recorded read of one clears the flag
  logic [7:0] zero_clr;
  assign zero_clr = wr_status ? (~writedata[7:0] & seen_q & SSF_CLR_MASK) : SSF_BYTE_ZERO;

  // ----------------------------------------------------------------
  // Receive event qualification
  // ----------------------------------------------------------------
  logic rx_take;
  logic fr_err;
  logic par_err;
  logic rx_err;
  logic rx_ovr;
  logic rx_good;

  // Halted or disabled receiver drops the event entirely
  assign rx_take = rx_evt.done & ctrl_q[SSF_C_RE] & ~fault_now;
  // Incoming stop is the first stop bit; the second is never looked at
  assign fr_err = ~ctrl_q[SSF_C_SYNC] & ~rx_evt.stop;
  assign par_err = ~ctrl_q[SSF_C_SYNC] & ctrl_q[SSF_C_PEN]
                   & ((^{rx_evt.data, rx_evt.parity}) != ctrl_q[SSF_C_PODD]);
  assign rx_err = fr_err | par_err;
  assign rx_ovr = rx_take & status_q[SSF_B_RDF];
  assign rx_good = rx_take & ~status_q[SSF_B_RDF] & ~rx_err;

  // Mp bit is taken even from an errored byte, so software sees what came in
  logic mp_take;
  assign mp_take = rx_take & ctrl_q[SSF_C_MP] & ~ctrl_q[SSF_C_SYNC];

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // One wait cycle per access so read data is steady at acceptance
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      waitreq_q <= 1'b1;
    end else if (req && waitreq_q) begin
      waitreq_q <= 1'b0;
    end else begin
      waitreq_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && waitreq_q) begin
      case (ofs)
        SSF_OFS_STATUS: rdata_q <= {24'h00_0000, status_q};
        SSF_OFS_CTRL: rdata_q <= {25'h000_0000, ctrl_q};
        SSF_OFS_TXHOLD: rdata_q <= {24'h00_0000, tx_hold_q};
        SSF_OFS_RXHOLD: rdata_q <= {24'h00_0000, rx_hold_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control and data registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= SSF_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= writedata[6:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_hold_q <= SSF_BYTE_ZERO;
    end else if (wr_tx) begin
      tx_hold_q <= writedata[7:0];
    end
  end

  // Errored bytes still land here; overrun keeps the older byte
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_hold_q <= SSF_BYTE_ZERO;
    end else if (rx_take && !rx_ovr) begin
      rx_hold_q <= rx_evt.data;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b || low_power) begin
      status_q[SSF_B_TDE] <= SSF_STATUS_RST[SSF_B_TDE];
    end else if (tx_load || !ctrl_q[SSF_C_TE]) begin
      status_q[SSF_B_TDE] <= 1'b1;
    end else if (wr_tx || zero_clr[SSF_B_TDE]) begin
      status_q[SSF_B_TDE] <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b || low_power) begin
      status_q[SSF_B_RDF] <= SSF_STATUS_RST[SSF_B_RDF];
    end else if (rx_good) begin
      status_q[SSF_B_RDF] <= 1'b1;
    end else if (rd_rx || zero_clr[SSF_B_RDF]) begin
      status_q[SSF_B_RDF] <= 1'b0;
    end
  end

  // Error flags: set beats a same-cycle clear
  always_ff @(posedge clock) begin
    if (!rst_b || low_power) begin
      status_q[SSF_B_OVR] <= SSF_STATUS_RST[SSF_B_OVR];
    end else if (rx_ovr) begin
      status_q[SSF_B_OVR] <= 1'b1;
    end else if (zero_clr[SSF_B_OVR]) begin
      status_q[SSF_B_OVR] <= 1'b0;
    end
  end

  // Overrun byte is never checked, so it raises no framing or parity flag
  always_ff @(posedge clock) begin
    if (!rst_b || low_power) begin
      status_q[SSF_B_FRM] <= SSF_STATUS_RST[SSF_B_FRM];
    end else if (rx_take && !rx_ovr && fr_err) begin
      status_q[SSF_B_FRM] <= 1'b1;
    end else if (zero_clr[SSF_B_FRM]) begin
      status_q[SSF_B_FRM] <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b || low_power) begin
      status_q[SSF_B_PAR] <= SSF_STATUS_RST[SSF_B_PAR];
    end else if (rx_take && !rx_ovr && par_err) begin
      status_q[SSF_B_PAR] <= 1'b1;
    end else if (zero_clr[SSF_B_PAR]) begin
      status_q[SSF_B_PAR] <= 1'b0;
    end
  end

  // Last bit with nothing queued, or transmitter off, ends the transfer
  logic tfn_set;
  assign tfn_set = (tx_last_bit & status_q[SSF_B_TDE]) | ~ctrl_q[SSF_C_TE];

  // Finished flag takes no bus data; a holding write or a holding-empty clear drops it
  always_ff @(posedge clock) begin
    if (!rst_b || low_power) begin
      status_q[SSF_B_TFN] <= SSF_STATUS_RST[SSF_B_TFN];
    end else if (tfn_set) begin
      status_q[SSF_B_TFN] <= 1'b1;
    end else if (wr_tx || zero_clr[SSF_B_TDE]) begin
      status_q[SSF_B_TFN] <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b || low_power) begin
      status_q[SSF_B_MPI] <= SSF_STATUS_RST[SSF_B_MPI];
    end else if (mp_take) begin
      status_q[SSF_B_MPI] <= rx_evt.mp;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b || low_power) begin
      status_q[SSF_B_MPO] <= SSF_STATUS_RST[SSF_B_MPO];
    end else if (wr_status) begin
      status_q[SSF_B_MPO] <= writedata[SSF_B_MPO];
    end
  end

  // ----------------------------------------------------------------
  // Read-as-one record
  // ----------------------------------------------------------------
  // Record goes stale once the flag drops, so a new set needs a new read
  always_ff @(posedge clock) begin
    if (!rst_b || low_power) begin
      seen_q <= SSF_BYTE_ZERO;
    end else begin
      seen_q <= (seen_q | (rd_status ? rdata_q[7:0] : SSF_BYTE_ZERO))
                & status_q & SSF_CLR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Halt controls
  // ----------------------------------------------------------------
  // Registered for the shifter; the receive gate itself uses the live flags
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_halt_q <= 1'b0;
    end else begin
      rx_halt_q <= fault_now;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_halt_q <= 1'b0;
    end else begin
      tx_halt_q <= ctrl_q[SSF_C_SYNC] & fault_now;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign readdata = rdata_q;
  assign waitrequest = waitreq_q;
  assign tx_holding = tx_hold_q;
  assign tx_holding_empty = status_q[SSF_B_TDE];
  assign mp_bit_out = status_q[SSF_B_MPO];
  // Field by field: the struct lists enable first, the register holds it at bit 0
  assign cfg = {ctrl_q[SSF_C_TE],
                ctrl_q[SSF_C_RE],
                ctrl_q[SSF_C_SYNC],
                ctrl_q[SSF_C_PEN],
                ctrl_q[SSF_C_PODD],
                ctrl_q[SSF_C_STOP2],
                ctrl_q[SSF_C_MP]};
  assign rx_halt = rx_halt_q;
  assign tx_halt = tx_halt_q;

endmodule

// >>> dv/ssf_status_monitor.sv
// Checker for the serial status flag block.
// Sees only the top ports; one clock, synchronous reset.
`timescale 1ns/10ps
module ssf_status_mon
  import ssf_pkg::*;
#(parameter int ADDR_W = 4) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic low_power,
  // Bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Shift side
  input wire logic tx_load,
  input wire logic tx_last_bit,
  input wire ssf_pkg::ssf_rx_evt_s rx_evt,
  input wire logic [7:0] tx_holding,
  input wire logic tx_holding_empty,
  input wire logic mp_bit_out,
  input wire ssf_pkg::ssf_cfg_s cfg,
  input wire logic rx_halt,
  input wire logic tx_halt
);
  wire logic wr_ok = write && !waitrequest && byteenable[0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence st_rd;
    read && waitrequest && address == 4'h0;
  endsequence
  sequence rd_ans;
    !waitrequest && readdata[7] == $past(tx_holding_empty)
      && readdata[0] == $past(mp_bit_out) && readdata[31:8] == 24'h0;
  endsequence
  AST_INIT: assert property (disable iff (1'b0)
    !rst_b || low_power |=> tx_holding_empty && !mp_bit_out) else $error("no reload");
  AST_STRD: assert property (st_rd |=> rd_ans ##1 waitrequest)
    else $error("bad status read");
  AST_LOAD: assert property (tx_load |=> tx_holding_empty)
    else $error("load kept flag low");
  AST_TXOFF: assert property (!cfg.tx_en |=> tx_holding_empty)
    else $error("tx off kept flag low");
  AST_TXWR: assert property (wr_ok && address == 4'h8 && cfg.tx_en && !tx_load
    && !low_power |=> !tx_holding_empty && tx_holding == $past(writedata[7:0]))
    else $error("holding write missed");
  AST_FALL: assert property ($fell(tx_holding_empty) |-> $past(wr_ok && !address[2]))
    else $error("empty flag fell alone");
  AST_MPO: assert property ($changed(mp_bit_out)
    |-> $past(wr_ok && address == 4'h0 || low_power)) else $error("mp bit moved");
  AST_RXH: assert property ($rose(rx_halt) |-> $past(rx_evt.done, 2))
    else $error("halt without event");
  AST_TXH: assert property (tx_halt == ($past(cfg.sync_mode) && rx_halt))
    else $error("tx halt wrong");
endmodule

bind ssf_status ssf_status_mon #(.ADDR_W(ADDR_W)) u_mon (.clock, .rst_b, .low_power,
  .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .tx_load,
  .tx_last_bit, .rx_evt, .tx_holding, .tx_holding_empty, .mp_bit_out, .cfg, .rx_halt,
  .tx_halt);

// >>> dv/ssf_far_end.sv
// Far-end stand-in: shift logic pulses toward the status block.
// Callers sit just after a rising clock edge.
`timescale 1ns/10ps
module ssf_far_end
  import ssf_pkg::*;
(
  // Clock and events
  input wire logic clock,
  output logic tx_load,
  output logic tx_last_bit,
  output ssf_pkg::ssf_rx_evt_s rx_evt
);
  initial begin
    tx_load = 1'b0;
    tx_last_bit = 1'b0;
    rx_evt = '0;
  end
  // Stale fields inverted, so nothing reads them by luck
  task automatic send(input logic [7:0] d, input logic s, p, m);
    @(posedge clock);
    rx_evt <= {1'b1, d, s, p, m};
    @(posedge clock);
    rx_evt <= {1'b0, ~d, ~s, ~p, ~m};
  endtask
  task automatic pulse(input logic last);
    @(posedge clock);
    tx_load <= !last;
    tx_last_bit <= last;
    @(posedge clock);
    tx_load <= 1'b0;
    tx_last_bit <= 1'b0;
  endtask
endmodule

// >>> dv/tb_ssf_status.sv
// Testbench for the serial status flag block.
// Drives the Avalon slave and the far-end stand-in.
`timescale 1ns/10ps
module tb_ssf_status;
  import ssf_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic low_power = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, tx_load, tx_last_bit, tx_holding_empty, mp_bit_out, rx_halt, tx_halt;
  logic [7:0] tx_holding;
  ssf_rx_evt_s rx_evt;
  ssf_cfg_s cfg;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  ssf_status dut (.clock, .rst_b, .low_power, .address, .read, .write, .byteenable(4'hF),
    .writedata, .readdata, .waitrequest, .tx_load, .tx_last_bit, .rx_evt, .tx_holding,
    .tx_holding_empty, .mp_bit_out, .cfg, .rx_halt, .tx_halt);
  ssf_far_end far (.clock, .tx_load, .tx_last_bit, .rx_evt);
  initial forever #2.5 clock = ~clock;
  // Hang guard, well above the 150 or so cycles used
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end
  task give_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task st(input logic [7:0] e);
    bus(1'b0, 4'h0, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task lp();
    @(posedge clock);
    low_power <= 1'b1;
    @(posedge clock);
    low_power <= 1'b0;
  endtask
  task t_tx();
    bus(1'b1, 4'h4, 8'h01);
    bus(1'b1, 4'h0, 8'h00);
    st(8'h84);
    bus(1'b1, 4'h0, 8'h00);
    st(8'h00);
    far.pulse(1'b0);
    st(8'h80);
    chk(32'(tx_holding_empty), 32'h1);
    far.pulse(1'b1);
    st(8'h84);
    bus(1'b1, 4'h8, 8'hA5);
    st(8'h00);
    chk(32'(tx_holding), 32'hA5);
    bus(1'b1, 4'h0, 8'hFF);
    st(8'h01);
    chk(32'(mp_bit_out), 32'h1);
    bus(1'b1, 4'h4, 8'h00);
    st(8'h85);
  endtask
  task t_rx();
    lp();
    st(8'h84);
    bus(1'b1, 4'h4, 8'h4A);
    far.send(8'h5A, 1'b1, 1'b0, 1'b1);
    st(8'hC6);
    chk(32'(cfg), 32'h29);
    far.send(8'h33, 1'b1, 1'b0, 1'b1);
    st(8'hE6);
    chk(32'(rx_halt), 32'h1);
    bus(1'b0, 4'hC, 8'h00);
    chk(rd, 32'h5A);
    st(8'hA6);
    far.send(8'h0F, 1'b1, 1'b0, 1'b1);
    bus(1'b0, 4'hC, 8'h00);
    chk(rd, 32'h5A);
    bus(1'b1, 4'h4, 8'h48);
    st(8'hA6);
    bus(1'b1, 4'h0, 8'h00);
    st(8'h86);
    far.send(8'h11, 1'b1, 1'b0, 1'b1);
    st(8'h86);
    bus(1'b0, 4'hC, 8'h00);
    chk(rd, 32'h5A);
  endtask
  task t_err();
    lp();
    bus(1'b1, 4'h4, 8'h0A);
    far.send(8'hC3, 1'b0, 1'b0, 1'b1);
    st(8'h94);
    bus(1'b0, 4'hC, 8'h00);
    chk(rd, 32'hC3);
    bus(1'b1, 4'h0, 8'h00);
    far.send(8'h01, 1'b1, 1'b0, 1'b0);
    st(8'h8C);
    bus(1'b0, 4'hC, 8'h00);
    chk(rd, 32'h01);
    bus(1'b1, 4'h4, 8'h1A);
    bus(1'b1, 4'h0, 8'h00);
    far.send(8'h01, 1'b1, 1'b0, 1'b0);
    st(8'hC4);
    bus(1'b1, 4'h4, 8'h06);
    far.send(8'h77, 1'b0, 1'b1, 1'b0);
    st(8'hE4);
    chk(32'(tx_halt), 32'h1);
    lp();
    st(8'h84);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    t_tx();
    t_rx();
    t_err();
    give_verdict();
  end
endmodule
